// ===== src/ncai_fifo.sv
`default_nettype none
module ncai_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic push;
	logic pop;

	// flags are registered from the next count so both sides see honest full and empty
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign cnt_d = cnt_q + CW'(push) - CW'(pop);
	assign out_data_out = mem_q[rp_q];

	// occupancy and flags
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			in_ready_out <= cnt_d != CW'(DEPTH);
			out_valid_out <= cnt_d != '0;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
			end
		end
	end

	// storage needs no reset
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wp_q] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// ===== src/ncai_host.sv
`default_nettype none
module ncai_host #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire ncai_pkg::ncai_req_s cmd_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [7:0] wr_data_in,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	output logic done_out,
	output logic prog_fail_out,
	output logic prev_fail_out,
	input wire logic protect_in,
	output logic cle_out,
	output logic ale_out,
	output logic ce_n_out,
	output logic we_n_out,
	output logic output_strobe_n_out,
	output logic wp_n_out,
	output logic [7:0] io_out,
	output logic io_oe_n_out,
	input wire logic [7:0] io_in,
	input wire logic done_indicator_in
);
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_RDYW = 9'h002,
		S_C1 = 9'h004,
		S_ADDR = 9'h008,
		S_WDATA = 9'h010,
		S_C2 = 9'h020,
		S_BUSY = 9'h040,
		S_GAP = 9'h080,
		S_RDATA = 9'h100
	} ncai_state_e;

	ncai_state_e state_q;
	ncai_state_e nxt;
	ncai_state_e post_st;
	ncai_state_e after_a;
	ncai_state_e after_c1;
	ncai_pkg::ncai_dec_s dec_q;
	logic [ncai_pkg::ROW_W-1:0] row_q;
	logic [ncai_pkg::COL_W-1:0] col_q;
	logic [13:0] cnt_q;
	logic [7:0] t_q;
	logic [7:0] gap_lim_q;
	logic [2:0] a_q;
	logic [7:0] wbyte_q;
	logic [7:0] abyte;
	logic [7:0] io_s1_q;
	logic [7:0] io_s2_q;
	logic rdy_s1_q;
	logic rdy_s2_q;
	logic wend;
	logic rend;
	logic wcyc;
	logic stall;
	logic take;
	logic capture;
	logic f_valid;
	logic [7:0] f_data;

	// write data waits here; an empty buffer holds the write strobe off
	ncai_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk_in(mclk_in),
		.rst_in(rst_in),
		.in_valid_in(wr_valid_in),
		.in_ready_out(wr_ready_out),
		.in_data_in(wr_data_in),
		.out_valid_out(f_valid),
		.out_ready_in(take),
		.out_data_out(f_data)
	);

	// pins from the far side pass two flops; the first feeds only the second
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end else begin
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
			rdy_s1_q <= done_indicator_in;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// strobe phase markers and data buffer handshake
	assign wend = t_q == 8'(ncai_pkg::WCYC - 1);
	assign rend = t_q == 8'(ncai_pkg::RCYC - 1);
	assign wcyc = (state_q == S_C1) || (state_q == S_ADDR) || (state_q == S_WDATA)
		|| (state_q == S_C2);
	assign stall = (state_q == S_WDATA) && (t_q == 8'h00) && !f_valid;
	assign take = (state_q == S_WDATA) && (t_q == 8'h00) && f_valid;
	assign capture = (state_q == S_RDATA) && (t_q == 8'(ncai_pkg::RLO_CYC - 1));

	// successor states shared by several steps
	always_comb begin
		if (dec_q.wait_rdy) begin
			post_st = S_BUSY;
		end else if (dec_q.dir == ncai_pkg::DIR_RD) begin
			post_st = S_GAP;
		end else begin
			post_st = S_IDLE;
		end
		if (dec_q.dir == ncai_pkg::DIR_WR) begin
			after_a = S_GAP;
		end else if (dec_q.has_c2) begin
			after_a = S_C2;
		end else begin
			after_a = post_st;
		end
		after_c1 = dec_q.has_addr ? S_ADDR : after_a;
	end

	// sequencer: command, address, data and confirm in the order each operation needs
	always_comb begin
		nxt = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (cmd_valid_in) begin
					nxt = S_RDYW;
				end
			end
			S_RDYW: begin
				if (dec_q.any_time || rdy_s2_q) begin
					nxt = S_C1;
				end
			end
			S_C1: begin
				if (wend) begin
					nxt = after_c1;
				end
			end
			S_ADDR: begin
				if (wend && a_q == dec_q.a_last) begin
					nxt = after_a;
				end
			end
			S_WDATA: begin
				if (wend && cnt_q == 14'h0001) begin
					nxt = S_IDLE;
				end
			end
			S_C2: begin
				if (wend) begin
					nxt = post_st;
				end
			end
			S_BUSY: begin
				if (t_q >= 8'(ncai_pkg::WB_CYC) && rdy_s2_q) begin
					nxt = (dec_q.dir == ncai_pkg::DIR_RD) ? S_GAP : S_IDLE;
				end
			end
			S_GAP: begin
				if (t_q == gap_lim_q) begin
					if (cnt_q == 14'h0000) begin
						nxt = S_IDLE;
					end else begin
						nxt = (dec_q.dir == ncai_pkg::DIR_WR) ? S_WDATA : S_RDATA;
					end
				end
			end
			S_RDATA: begin
				if (rend && cnt_q == 14'h0001) begin
					nxt = S_IDLE;
				end
			end
			default: nxt = S_IDLE;
		endcase
	end

	// state, handshake and completion pulse
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= S_IDLE;
			cmd_ready_out <= 1'b1;
			done_out <= 1'b0;
		end else begin
			state_q <= nxt;
			cmd_ready_out <= nxt == S_IDLE;
			done_out <= (state_q != S_IDLE) && (nxt == S_IDLE);
		end
	end

	// phase timer: restarts on each state change and each byte boundary
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			t_q <= 8'h00;
		end else if (nxt != state_q) begin
			t_q <= 8'h00;
		end else if (stall) begin
			t_q <= t_q;
		end else if ((wcyc && wend) || (state_q == S_RDATA && rend)) begin
			t_q <= 8'h00;
		end else if (t_q != 8'hFF) begin
			t_q <= t_q + 8'h01;
		end
	end

	// request fields, address index and byte count
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			dec_q <= '0;
			row_q <= '0;
			col_q <= '0;
			cnt_q <= 14'h0000;
			a_q <= 3'h0;
			gap_lim_q <= 8'h00;
			wbyte_q <= 8'h00;
		end else begin
			if (state_q == S_IDLE && cmd_valid_in) begin
				dec_q <= ncai_pkg::ncai_decode(cmd_in.op);
				row_q <= cmd_in.row;
				// identification takes a single zero address byte
				col_q <= (cmd_in.op == ncai_pkg::OP_ID) ? '0 : cmd_in.col;
				cnt_q <= (cmd_in.op == ncai_pkg::OP_STATUS) ? 14'h0001 : cmd_in.len;
			end
			if (state_q == S_RDYW || (state_q == S_ADDR && wend)) begin
				a_q <= (state_q == S_RDYW) ? dec_q.a_first : a_q + 3'h1;
			end
			if ((state_q == S_WDATA && wend) || (state_q == S_RDATA && rend)) begin
				cnt_q <= cnt_q - 14'h0001;
			end
			// data input waits the shorter hold after the last address byte; reads wait the longer one
			if (nxt == S_GAP && state_q != S_GAP) begin
				gap_lim_q <= (dec_q.dir == ncai_pkg::DIR_WR) ? 8'(ncai_pkg::WHW_CYC - 1)
					: 8'(ncai_pkg::WHR_CYC - 1);
			end
			if (take) begin
				wbyte_q <= f_data;
			end
		end
	end

	// address byte layout: column low, column high, row low, row mid, row top
	always_comb begin
		unique case (a_q)
			3'h0: abyte = col_q[7:0];
			3'h1: abyte = {2'h0, col_q[13:8]};
			3'h2: abyte = row_q[7:0];
			3'h3: abyte = row_q[15:8];
			default: abyte = {6'h0, row_q[17:16]};
		endcase
	end

	// pin drive: latches and data settle before the write strobe falls, hold after it rises
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cle_out <= 1'b0;
			ale_out <= 1'b0;
			ce_n_out <= 1'b1;
			we_n_out <= 1'b1;
			output_strobe_n_out <= 1'b1;
			io_out <= 8'h00;
			io_oe_n_out <= 1'b1;
		end else begin
			cle_out <= (state_q == S_C1) || (state_q == S_C2);
			ale_out <= state_q == S_ADDR;
			ce_n_out <= state_q == S_IDLE;
			// strobes stay high outside their own cycles, so busy waits are quiet
			we_n_out <= !(wcyc && !stall && t_q >= 8'(ncai_pkg::SU_CYC)
				&& t_q < 8'(ncai_pkg::SU_CYC + ncai_pkg::WLO_CYC));
			output_strobe_n_out <= !(state_q == S_RDATA
				&& t_q < 8'(ncai_pkg::RLO_CYC));
			io_oe_n_out <= !wcyc;
			if (state_q == S_C2) begin
				io_out <= dec_q.c2;
			end else if (state_q == S_ADDR) begin
				io_out <= abyte;
			end else if (state_q == S_WDATA) begin
				io_out <= wbyte_q;
			end else begin
				io_out <= dec_q.c1;
			end
		end
	end

	// read bytes are taken late in the low phase, past access time plus sync delay
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= 8'h00;
			prog_fail_out <= 1'b0;
			prev_fail_out <= 1'b0;
		end else begin
			rd_valid_out <= capture;
			if (capture) begin
				rd_data_out <= io_s2_q;
			end
			if (capture && dec_q.c1 == ncai_pkg::CMD_STATUS) begin
				prog_fail_out <= io_s2_q[ncai_pkg::ST_PAGE_FAIL];
				prev_fail_out <= io_s2_q[ncai_pkg::ST_PREV_FAIL];
			end
		end
	end

	// write protect follows software request; protected means program and erase fail
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_n_out <= 1'b0;
		end else begin
			wp_n_out <= !protect_in;
		end
	end
endmodule
`default_nettype wire

// ===== src/ncai_pkg.sv
`default_nettype none
package ncai_pkg;
	// pin timing, figures in ns
	localparam int CLK_NS = 4;
	localparam int T_SETUP_NS = 12;
	localparam int T_WC_NS = 25;
	localparam int T_WH_NS = 10;
	localparam int T_REA_NS = 20;
	localparam int T_REH_NS = 10;
	localparam int T_WHR_NS = 180;
	localparam int T_WHW_NS = 80;
	localparam int T_WB_NS = 100;
	localparam int SYNC_STAGES = 2;
	// derived cycle counts; least times round up
	localparam int SU_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WLO_CYC = (T_WC_NS - T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHI_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WCYC = SU_CYC + WLO_CYC + WHI_CYC;
	localparam int RLO_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1;
	localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCYC = RLO_CYC + REH_CYC;
	localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHW_CYC = (T_WHW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	// array geometry
	localparam int PAGE_BYTES = 8568;
	localparam int MAIN_BYTES = 8192;
	localparam int SPARE_BYTES = 376;
	localparam int PAGES_PER_BLOCK = 128;
	localparam int COL_W = 14;
	localparam int ROW_W = 18;
	localparam int PAGE_IN_BLK_W = 7;
	// command codes
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_COPY_GO = 8'h3A;
	localparam logic [7:0] CMD_COL_RD = 8'h05;
	localparam logic [7:0] CMD_COL_RD_GO = 8'hE0;
	localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
	localparam logic [7:0] CMD_LOAD = 8'h80;
	localparam logic [7:0] CMD_COL_WR = 8'h85;
	localparam logic [7:0] CMD_COPY_LOAD = 8'h8C;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	// status byte bit positions
	localparam int ST_PAGE_FAIL = 0;
	localparam int ST_PREV_FAIL = 1;
	localparam int ST_PAGE_RDY = 5;
	localparam int ST_CACHE_RDY = 6;

	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_COPY_READ = 4'h1, OP_CACHE_NEXT = 4'h2, OP_CACHE_LAST = 4'h3,
		OP_COL_READ = 4'h4, OP_LOAD = 4'h5, OP_COL_WRITE = 4'h6, OP_COPY_LOAD = 4'h7,
		OP_PROG = 4'h8, OP_PROG_CACHE = 4'h9, OP_ERASE = 4'hA, OP_ID = 4'hB,
		OP_STATUS = 4'hC, OP_RESET = 4'hD
	} ncai_op_e;

	typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_WR = 2'h1, DIR_RD = 2'h2} ncai_dir_e;

	typedef struct packed {
		ncai_op_e op;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [13:0] len;
	} ncai_req_s;

	typedef struct packed {
		logic [7:0] c1;
		logic has_c2;
		logic [7:0] c2;
		logic has_addr;
		logic [2:0] a_first;
		logic [2:0] a_last;
		ncai_dir_e dir;
		logic wait_rdy;
		logic any_time;
	} ncai_dec_s;

	// one line per operation: first code, confirm, address bytes, data direction, busy wait
	function automatic ncai_dec_s ncai_decode(input ncai_op_e op);
		ncai_dec_s d;
		d = '0;
		unique case (op)
			OP_READ: d = {CMD_READ, 1'h1, CMD_READ_GO, 1'h1, 3'h0, 3'h4, DIR_RD, 1'h1, 1'h0};
			OP_COPY_READ: d = {CMD_READ, 1'h1, CMD_COPY_GO, 1'h1, 3'h0, 3'h4, DIR_RD, 1'h1, 1'h0};
			OP_CACHE_NEXT: d = {CMD_CACHE_NEXT, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_RD, 1'h1, 1'h0};
			OP_CACHE_LAST: d = {CMD_CACHE_LAST, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_RD, 1'h1, 1'h0};
			OP_COL_READ: d = {CMD_COL_RD, 1'h1, CMD_COL_RD_GO, 1'h1, 3'h0, 3'h1, DIR_RD, 1'h0, 1'h0};
			OP_LOAD: d = {CMD_LOAD, 1'h0, 8'h00, 1'h1, 3'h0, 3'h4, DIR_WR, 1'h0, 1'h0};
			OP_COL_WRITE: d = {CMD_COL_WR, 1'h0, 8'h00, 1'h1, 3'h0, 3'h1, DIR_WR, 1'h0, 1'h0};
			OP_COPY_LOAD: d = {CMD_COPY_LOAD, 1'h0, 8'h00, 1'h1, 3'h0, 3'h4, DIR_WR, 1'h0, 1'h0};
			OP_PROG: d = {CMD_PROG, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_NONE, 1'h1, 1'h0};
			OP_PROG_CACHE: d = {CMD_PROG_CACHE, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_NONE, 1'h1, 1'h0};
			OP_ERASE: d = {CMD_ERASE, 1'h1, CMD_ERASE_GO, 1'h1, 3'h2, 3'h4, DIR_NONE, 1'h1, 1'h0};
			OP_ID: d = {CMD_ID, 1'h0, 8'h00, 1'h1, 3'h0, 3'h0, DIR_RD, 1'h0, 1'h0};
			OP_STATUS: d = {CMD_STATUS, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_RD, 1'h0, 1'h1};
			OP_RESET: d = {CMD_RESET, 1'h0, 8'h00, 1'h0, 3'h0, 3'h0, DIR_NONE, 1'h1, 1'h1};
			default: d = '0;
		endcase
		return d;
	endfunction
endpackage
`default_nettype wire

// ===== test/ncai_host_asserts.sv
`default_nettype none
module ncai_host_asserts (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire logic protect_in,
	input wire logic cle_out,
	input wire logic ale_out,
	input wire logic ce_n_out,
	input wire logic we_n_out,
	input wire logic output_strobe_n_out,
	input wire logic wp_n_out,
	input wire logic [7:0] io_out,
	input wire logic io_oe_n_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// a mixed latch cycle would be taken as a command, never as an address byte
	property p_latch; !(cle_out && ale_out); endproperty
	a_latch: assert property (p_latch) else $error("both latches high");
	property p_drive; !we_n_out |-> !ce_n_out && !io_oe_n_out; endproperty
	a_drive: assert property (p_drive) else $error("write strobe without port drive");
	// the byte must not move while the strobe rises
	property p_hold; $rose(we_n_out) |-> $stable(io_out) && $stable(ale_out); endproperty
	a_hold: assert property (p_hold) else $error("port moved at strobe rise");
	property p_width; $fell(we_n_out) |-> !we_n_out [*4] ##1 we_n_out; endproperty
	a_width: assert property (p_width) else $error("write strobe width wrong");
	property p_setup; $fell(we_n_out) |-> $past(cle_out, 3) == cle_out; endproperty
	a_setup: assert property (p_setup) else $error("latch setup too short");
	// host must let go of the port while the device drives it
	property p_float;
		!output_strobe_n_out |-> io_oe_n_out && we_n_out && !cle_out && !ale_out && !ce_n_out;
	endproperty
	a_float: assert property (p_float) else $error("port driven during read");
	property p_take; cmd_valid_in && cmd_ready_out |=> !cmd_ready_out; endproperty
	a_take: assert property (p_take) else $error("ready stayed high after take");
	property p_wp; !$past(rst_in) |-> wp_n_out == !$past(protect_in); endproperty
	a_wp: assert property (p_wp) else $error("protect pin lags");
endmodule
bind ncai_host ncai_host_asserts ncai_host_asserts_inst (
	.mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
	.cmd_ready_out(cmd_ready_out), .protect_in(protect_in), .cle_out(cle_out),
	.ale_out(ale_out), .ce_n_out(ce_n_out), .we_n_out(we_n_out),
	.output_strobe_n_out(output_strobe_n_out), .wp_n_out(wp_n_out), .io_out(io_out),
	.io_oe_n_out(io_oe_n_out)
);
`default_nettype wire

// ===== test/ncai_nand_model.sv
`default_nettype none
module ncai_nand_model #(
	parameter int BUSY_CYC = 60,
	parameter logic INIT_AT_RESET = 1'b1,
	parameter logic [7:0] ID0 = 8'hA5, // arbitrary value
	parameter logic [7:0] ID1 = 8'h3C // arbitrary value
) (
	input wire logic clk_in,
	input wire logic cle_in,
	input wire logic ale_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic re_n_in,
	input wire logic wp_n_in,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic drv_out,
	output logic rdy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd;
	logic [13:0] col;
	logic [17:0] row;
	logic [7:0] wbuf[$];
	logic fail = 1'b0, prev_fail = 1'b0;
	logic standby;
	// power-on initialisation keeps the part busy unless it is put off to the first reset
	int acnt, idx, busy = INIT_AT_RESET ? 0 : BUSY_CYC, starts = 0, seen = 0;
	// capture on the write strobe rise while selected
	always @(posedge we_n_in) if (!ce_n_in) begin
		if (cle_in) begin
			cmd = io_in;
			acnt = (io_in == 8'h60) ? 2 : 0;
			idx = 0;
			if (io_in == 8'h80) wbuf = {};
			if (io_in inside {8'h31, 8'h3F}) begin
				row = row + 18'h00001;
				col = 14'h0000;
			end
			if (io_in inside {8'h10, 8'h15, 8'hD0}) begin
				if (io_in != 8'hD0) prev_fail = fail;
				fail = !wp_n_in;
				if (wp_n_in) starts++;
			end else if (io_in inside {8'h30, 8'h3A, 8'h31, 8'h3F, 8'hFF}) begin
				starts++;
			end
		end else if (ale_in) begin
			case (acnt)
				0: col[7:0] = io_in;
				1: col[13:8] = io_in[5:0];
				2: row[7:0] = io_in;
				3: row[15:8] = io_in;
				default: row[17:16] = io_in[1:0];
			endcase
			acnt++;
		end else wbuf.push_back(io_in);
	end
	// launches are counted so that only this process owns the timer
	always @(posedge clk_in) begin
		if (starts != seen) begin
			busy = BUSY_CYC;
			seen = starts;
		end else if (busy > 0) busy--;
		rdy_out <= (busy == 0) && (starts == seen);
	end
	// deselect only counts as standby while ready
	always @(posedge ce_n_in) standby = rdy_out;
	// each strobe fall gives the next byte; data lags by less than access time
	always @(negedge re_n_in) if (!ce_n_in) begin
		case (cmd)
			8'h70: io_out <= #5 {1'b0, rdy_out, rdy_out, 3'h0, prev_fail, fail};
			8'h90: io_out <= #5 (idx == 0) ? ID0 : ID1;
			default: io_out <= #5 8'(col[7:0] + row[7:0]);
		endcase
		idx++;
		col++;
	end
	assign drv_out = !re_n_in && !ce_n_in && !cle_in && !ale_in;
endmodule
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
		$display("Error t=%0t got %h exp %h", $time, a, b); end end
	logic mclk_in = 0, rst_in = 1, cmd_valid = 0, wr_valid = 0, protect = 0, saw_busy;
	ncai_pkg::ncai_req_s cmd = '0;
	logic [7:0] wr_data = 8'h00, last_io = 8'h00, io_out, dev_io, rd_data, io_bus;
	logic cmd_ready, wr_ready, rd_valid, done, pf, cle, ale, ce_n, we_n, re_n, wp_n, oe_n;
	logic drv, rdy, pvf;
	logic [7:0] rq[$];
	int error_cnt = 0, num_checks = 0;
	always #2 mclk_in = ~mclk_in;
	// an undriven port toggles so a stale byte cannot pass
	assign io_bus = !oe_n ? io_out : drv ? dev_io : ~last_io;
	always @(posedge mclk_in) last_io <= io_bus;
	ncai_host ncai_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
		.cmd_ready_out(cmd_ready), .cmd_in(cmd), .wr_valid_in(wr_valid),
		.wr_ready_out(wr_ready), .wr_data_in(wr_data), .rd_valid_out(rd_valid),
		.rd_data_out(rd_data), .done_out(done), .prog_fail_out(pf), .prev_fail_out(pvf),
		.protect_in(protect), .cle_out(cle), .ale_out(ale), .ce_n_out(ce_n), .we_n_out(we_n),
		.output_strobe_n_out(re_n), .wp_n_out(wp_n), .io_out(io_out), .io_oe_n_out(oe_n),
		.io_in(io_bus), .done_indicator_in(rdy));
	ncai_nand_model ncai_nand_model_inst (.clk_in(mclk_in), .cle_in(cle), .ale_in(ale),
		.ce_n_in(ce_n), .we_n_in(we_n), .re_n_in(re_n), .wp_n_in(wp_n), .io_in(io_bus),
		.io_out(dev_io), .drv_out(drv), .rdy_out(rdy));
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one operation from take to done, collecting read bytes
	task automatic run(input ncai_pkg::ncai_op_e op, input logic [17:0] r,
		input logic [13:0] c, input logic [13:0] len);
		int n;
		rq = {};
		saw_busy = 0;
		@(negedge mclk_in);
		`CHK(cmd_ready, 1'b1)
		cmd = '{op, r, c, len};
		cmd_valid = 1;
		@(negedge mclk_in);
		cmd_valid = 0;
		for (n = 0; n < 30000 && done !== 1'b1; n++) begin
			@(negedge mclk_in);
			if (rd_valid === 1'b1) rq.push_back(rd_data);
			if (rdy === 1'b0) saw_busy = 1;
		end
		if (n == 30000) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic push(input logic [7:0] b);
		@(negedge mclk_in);
		`CHK(wr_ready, 1'b1)
		wr_valid = 1;
		wr_data = b;
		@(negedge mclk_in);
		wr_valid = 0;
	endtask
	task automatic t_status_id;
		run(ncai_pkg::OP_STATUS, 0, 0, 1);
		`CHK(rq[0], 8'h60)
		`CHK(pf, 1'b0)
		// select rises one cycle after done, with the part ready
		@(negedge mclk_in);
		`CHK(ncai_nand_model_inst.standby, 1'b1)
		run(ncai_pkg::OP_ID, 0, 0, 2);
		`CHK(rq[0], 8'hA5)
		`CHK(rq[1], 8'h3C)
	endtask
	// column low byte wraps and carries into bit 13 mid-read
	task automatic t_read;
		logic [17:0] r = 18'h23456;
		logic [13:0] c = 14'h1FFE;
		run(ncai_pkg::OP_READ, r, c, 3);
		`CHK(saw_busy, 1'b1)
		`CHK(ncai_nand_model_inst.row[17:7], r[17:7])
		`CHK(ncai_nand_model_inst.col, c + 14'h0003)
		`CHK(ncai_pkg::PAGE_BYTES, ncai_pkg::MAIN_BYTES + ncai_pkg::SPARE_BYTES)
		for (int k = 0; k < 3; k++) `CHK(rq[k], 8'(c + k + r[7:0]))
		run(ncai_pkg::OP_CACHE_NEXT, 0, 0, 1);
		`CHK(rq[0], 8'h57)
		run(ncai_pkg::OP_CACHE_LAST, 0, 0, 1);
		`CHK(rq[0], 8'h58)
		run(ncai_pkg::OP_COL_READ, 0, 14'h0105, 2);
		`CHK(rq[0], 8'h5D)
		`CHK(rq[1], 8'h5E)
	endtask
	// fill the buffer until it refuses, then drain it into the page
	task automatic t_prog;
		for (int k = 0; k < 4; k++) push(8'(8'h10 + k));
		@(negedge mclk_in);
		`CHK(wr_ready, 1'b0)
		run(ncai_pkg::OP_LOAD, 18'h00080, 14'h0000, 4);
		`CHK(wr_ready, 1'b1)
		for (int k = 0; k < 4; k++) `CHK(ncai_nand_model_inst.wbuf[k], 8'(8'h10 + k))
		run(ncai_pkg::OP_PROG, 0, 0, 0);
		`CHK(saw_busy, 1'b1)
		run(ncai_pkg::OP_STATUS, 0, 0, 1);
		`CHK(pf, 1'b0)
	endtask
	task automatic t_protect;
		protect = 1;
		repeat (2) @(negedge mclk_in);
		`CHK(wp_n, 1'b0)
		run(ncai_pkg::OP_PROG, 0, 0, 0);
		`CHK(saw_busy, 1'b0)
		run(ncai_pkg::OP_STATUS, 0, 0, 1);
		`CHK(pf, 1'b1)
		`CHK(pvf, 1'b0)
		protect = 0;
		repeat (2) @(negedge mclk_in);
		`CHK(wp_n, 1'b1)
		// a passing program after the refused one moves the failure to the previous bit
		run(ncai_pkg::OP_PROG, 0, 0, 0);
		run(ncai_pkg::OP_STATUS, 0, 0, 1);
		`CHK(pf, 1'b0)
		`CHK(pvf, 1'b1)
	endtask
	task automatic t_erase_copy;
		run(ncai_pkg::OP_ERASE, 18'h3FF80, 0, 0);
		`CHK(ncai_nand_model_inst.row, 18'h3FF80)
		`CHK(saw_busy, 1'b1)
		run(ncai_pkg::OP_COPY_READ, 18'h00100, 14'h0002, 1);
		`CHK(rq[0], 8'h02)
		push(8'hC3);
		run(ncai_pkg::OP_COPY_LOAD, 18'h00200, 0, 1);
		`CHK(ncai_nand_model_inst.wbuf[$], 8'hC3)
		push(8'h5A);
		run(ncai_pkg::OP_COL_WRITE, 0, 14'h0040, 1);
		`CHK(ncai_nand_model_inst.col, 14'h0040)
		`CHK(ncai_nand_model_inst.wbuf[$], 8'h5A)
		run(ncai_pkg::OP_PROG_CACHE, 0, 0, 0);
		`CHK(saw_busy, 1'b1)
		run(ncai_pkg::OP_RESET, 0, 0, 0);
		`CHK(saw_busy, 1'b1)
	endtask
	initial begin
		repeat (3) @(negedge mclk_in);
		rst_in = 0;
		t_status_id();
		t_read();
		t_prog();
		t_protect();
		t_erase_copy();
		end_of_test();
	end
endmodule
`default_nettype wire
